// >>> dp_pkg.sv
package dp_pkg;
   localparam int unsigned XLEN = 32;
   localparam int unsigned SHW  = 5;

   // operation selects supplied by the decoder
   typedef enum logic [4:0] {
      op_nop,
      op_branch_if_zero,
      op_branch_if_nonzero,
      op_mul_accumulate,
      op_signed_long_mul_acc,
      op_unsigned_long_mul_double_acc,
      op_signed_long_mul,
      op_byte_reverse_word,
      op_byte_reverse_halves,
      op_byte_reverse_low_signed,
      op_rotate_through_carry,
      op_signed_field_extract,
      op_unsigned_field_extract,
      op_block_store_descending,
      op_block_load_ascending,
      op_write_special_reg,
      op_read_special_reg,
      op_irq_mask_set,
      op_irq_mask_clear,
      op_load_half_sign_ext
   } op_t;

   // condition flags held by the datapath
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
      logic q;
   } flags_t;

   // request from the decoder
   typedef struct packed {
      logic        valid;
      op_t         op;
      logic        set_flags;
      logic        wback;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      logic [31:0] d;
      logic [4:0]  lsb;
      logic [4:0]  width_m1;
      logic [15:0] reglist;
   } req_t;

   // result towards the register file
   typedef struct packed {
      logic        valid;
      logic [31:0] lo;
      logic [31:0] hi;
      logic        hi_valid;
      logic        branch_taken;
      logic [31:0] addr;
      logic [31:0] base_new;
      logic        base_we;
      logic [4:0]  xfer_count;
   } res_t;

   localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
   localparam logic [4:0]  FLAG_N_BIT  = 5'h1f;
   localparam logic [4:0]  FLAG_Z_BIT  = 5'h1e;
   localparam logic [4:0]  FLAG_C_BIT  = 5'h1d;
   localparam logic [4:0]  FLAG_V_BIT  = 5'h1c;
   localparam logic [4:0]  FLAG_Q_BIT  = 5'h1b;
endpackage

// >>> int_datapath.sv
// Behaviour
// - compare-and-branch tests register against zero; flags untouched
// - multiply-accumulate keeps low 32 bits; flags untouched
// - signed long multiply-accumulate adds signed product to 64-bit pair
// - unsigned long multiply adds two 32-bit values to product, 64-bit result
// - signed long multiply returns full 64-bit signed product
// - word byte-reverse swaps byte order across the whole word
// - halfword-pair byte-reverse swaps bytes within each half
// - low halfword byte-reverse then sign-extend to 32 bits
// - rotate through carry shifts right one, carry in at top, sets N Z C
// - signed field extract by lsb and width, sign-extended
// - unsigned field extract by lsb and width, zero-extended
// - descending block store ends just below base, optional writeback
// - ascending block load starts at base, optional writeback
// - special register write may update N Z C V from value
// - special register read copies value, flags unchanged
// - state change ops set or clear interrupt mask, flags unchanged
// - signed halfword load sign-extends 16 bits from base plus offset
`timescale 1ns/1ps
`default_nettype none
module int_datapath (
   input  wire logic          clock,
   input  wire logic          rstn,
   input  wire dp_pkg::req_t  req,
   input  wire logic [15:0]   half_rdata,
   output var  dp_pkg::res_t  res,
   output var  dp_pkg::flags_t flags,
   output logic               irq_masked
);
   dp_pkg::res_t   res_r,   res_nxt;
   dp_pkg::flags_t flags_r, flags_nxt;
   logic           mask_r,  mask_nxt;
   logic           ld_pend_r, ld_pend_nxt;

   logic [63:0] sprod, uprod;
   logic [31:0] rev_w, rev_h, rev_s, rrx_v, fld, ufld, sfld, fmask;
   logic [4:0]  cnt;

   // products share one signed and one unsigned multiplier
   // operands widened first so no tool keeps only a 32-bit product
   assign sprod = {{32{req.a[31]}}, req.a} * {{32{req.b[31]}}, req.b};
   assign uprod = {32'h0000_0000, req.a} * {32'h0000_0000, req.b};

   // byte reorderings as pure wiring
   assign rev_w = {req.a[7:0], req.a[15:8], req.a[23:16], req.a[31:24]};
   assign rev_h = {req.a[23:16], req.a[31:24], req.a[7:0], req.a[15:8]};
   assign rev_s = {{16{req.a[7]}}, req.a[7:0], req.a[15:8]};
   assign rrx_v = {flags_r.c, req.a[31:1]};

   // field extract; width beyond bit 31 is clipped by the mask
   assign fmask = (32'h0000_0001 << req.width_m1) * 32'h0000_0002 - 32'h0000_0001;
   assign fld   = (req.a >> req.lsb);
   assign ufld  = (req.width_m1 == 5'h1f) ? fld : (fld & fmask);
   assign sfld  = fld[req.width_m1] ? (ufld | ~fmask) : ufld;

   // population count of register list for block transfers
   always_comb begin
      cnt = 5'h00;
      for (int i = 0; i < 16; i++) begin
         cnt = cnt + 5'(req.reglist[i]);
      end
   end

   // next-value logic; flags hold unless an op is listed as updating them
   always_comb begin
      res_nxt     = '0;
      flags_nxt   = flags_r;
      mask_nxt    = mask_r;
      ld_pend_nxt = 1'b0;
      res_nxt.valid = req.valid;
      if (ld_pend_r) begin
         res_nxt.valid = 1'b1;
         res_nxt.lo    = {{16{half_rdata[15]}}, half_rdata};
      end
      if (req.valid) begin
         unique case (req.op)
            dp_pkg::op_nop: ;
            dp_pkg::op_branch_if_zero:
               res_nxt.branch_taken = (req.a == 32'h0000_0000);
            dp_pkg::op_branch_if_nonzero:
               res_nxt.branch_taken = (req.a != 32'h0000_0000);
            dp_pkg::op_mul_accumulate:
               res_nxt.lo = uprod[31:0] + req.c;
            dp_pkg::op_signed_long_mul_acc: begin
               {res_nxt.hi, res_nxt.lo} = sprod + {req.d, req.c};
               res_nxt.hi_valid = 1'b1;
            end
            dp_pkg::op_unsigned_long_mul_double_acc: begin
               {res_nxt.hi, res_nxt.lo} = uprod + {32'h0, req.c}
                                        + {32'h0, req.d};
               res_nxt.hi_valid = 1'b1;
            end
            dp_pkg::op_signed_long_mul: begin
               {res_nxt.hi, res_nxt.lo} = sprod;
               res_nxt.hi_valid = 1'b1;
            end
            dp_pkg::op_byte_reverse_word:       res_nxt.lo = rev_w;
            dp_pkg::op_byte_reverse_halves:     res_nxt.lo = rev_h;
            dp_pkg::op_byte_reverse_low_signed: res_nxt.lo = rev_s;
            dp_pkg::op_rotate_through_carry: begin
               res_nxt.lo = rrx_v;
               if (req.set_flags) begin
                  flags_nxt.n = rrx_v[31];
                  flags_nxt.z = (rrx_v == 32'h0000_0000);
                  flags_nxt.c = req.a[0];
               end
            end
            dp_pkg::op_signed_field_extract:    res_nxt.lo = sfld;
            dp_pkg::op_unsigned_field_extract:  res_nxt.lo = ufld;
            dp_pkg::op_block_store_descending: begin
               // first address is base minus 4*count, rising to base-4
               res_nxt.addr       = req.a - {25'h0, cnt, 2'b00};
               res_nxt.base_new   = req.a - {25'h0, cnt, 2'b00};
               res_nxt.base_we    = req.wback;
               res_nxt.xfer_count = cnt;
            end
            dp_pkg::op_block_load_ascending: begin
               res_nxt.addr       = req.a;
               res_nxt.base_new   = req.a + {25'h0, cnt, 2'b00};
               res_nxt.base_we    = req.wback;
               res_nxt.xfer_count = cnt;
            end
            dp_pkg::op_write_special_reg: begin
               res_nxt.lo = req.a;
               if (req.set_flags) begin
                  flags_nxt.n = req.a[dp_pkg::FLAG_N_BIT];
                  flags_nxt.z = req.a[dp_pkg::FLAG_Z_BIT];
                  flags_nxt.c = req.a[dp_pkg::FLAG_C_BIT];
                  flags_nxt.v = req.a[dp_pkg::FLAG_V_BIT];
               end
            end
            dp_pkg::op_read_special_reg:
               res_nxt.lo = {flags_r.n, flags_r.z, flags_r.c, flags_r.v,
                             flags_r.q, 27'h0};
            dp_pkg::op_irq_mask_set:   mask_nxt = 1'b1;
            dp_pkg::op_irq_mask_clear: mask_nxt = 1'b0;
            dp_pkg::op_load_half_sign_ext: begin
               // address out now, data returns next cycle
               res_nxt.valid = 1'b0;
               res_nxt.addr  = req.a + req.b;
               ld_pend_nxt   = 1'b1;
            end
            // unused select codes act as no operation
            default: ;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         res_r     <= '0;
         flags_r   <= '0;
         mask_r    <= 1'b0;
         ld_pend_r <= 1'b0;
      end else begin
         res_r     <= res_nxt;
         flags_r   <= flags_nxt;
         mask_r    <= mask_nxt;
         ld_pend_r <= ld_pend_nxt;
      end
   end

   assign res        = res_r;
   assign flags      = flags_r;
   assign irq_masked = mask_r;

   // checks
   property p_branch;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_branch_if_zero
         |=> res.branch_taken == ($past(req.a) == 32'h0) && $stable(flags);
   endproperty
   a_branch: assert property (p_branch) else $error("branch wrong");

   property p_mla;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_mul_accumulate
         |=> res.lo == 32'($past(req.a) * $past(req.b) + $past(req.c));
   endproperty
   a_mla: assert property (p_mla) else $error("mul acc wrong");

   property p_signed_long_mul;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_signed_long_mul
         |=> {res.hi, res.lo} == 64'($signed($past(req.a)) * $signed($past(req.b)));
   endproperty
   a_signed_long_mul: assert property (p_signed_long_mul) else $error("long mul wrong");

   property p_rev;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_byte_reverse_word
         |=> res.lo[7:0] == $past(req.a[31:24]) && res.lo[31:24] == $past(req.a[7:0]);
   endproperty
   a_rev: assert property (p_rev) else $error("reverse wrong");

   property p_rrx;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_rotate_through_carry
         |=> res.lo[31] == $past(flags.c) && $stable(flags.v);
   endproperty
   a_rrx: assert property (p_rrx) else $error("rotate wrong");

   property p_block_store_descending;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_block_store_descending
         |=> res.addr + {25'h0, res.xfer_count, 2'b00} == $past(req.a);
   endproperty
   a_block_store_descending: assert property (p_block_store_descending) else $error("store addr wrong");

   property p_mask;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_irq_mask_set |=> irq_masked && $stable(flags);
   endproperty
   a_mask: assert property (p_mask) else $error("mask not set");

   sequence s_ldh_issue;
      req.valid && req.op == dp_pkg::op_load_half_sign_ext;
   endsequence
   property p_ldh;
      @(posedge clock) disable iff (!rstn)
      s_ldh_issue ##1 1'b1 |=> res.valid && res.lo[31:16] == {16{$past(half_rdata[15])}};
   endproperty
   a_ldh: assert property (p_ldh) else $error("half load wrong");

   // remaining ops, each checked against an independent form of its result
   property p_bnz;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_branch_if_nonzero
         |=> res.branch_taken == ($past(req.a) != 32'h0) && $stable(flags);
   endproperty
   a_bnz: assert property (p_bnz) else $error("nonzero branch wrong");

   property p_signed_long_mul_acc;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_signed_long_mul_acc
         |=> {res.hi, res.lo} == ({{32{$past(req.a[31])}}, $past(req.a)}
                                 * {{32{$past(req.b[31])}}, $past(req.b)}
                                 + {$past(req.d), $past(req.c)});
   endproperty
   a_signed_long_mul_acc: assert property (p_signed_long_mul_acc) else $error("signed long mul acc wrong");

   property p_umlal;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_unsigned_long_mul_double_acc
         |=> {res.hi, res.lo} == ({32'h0, $past(req.a)} * {32'h0, $past(req.b)}
                                 + {32'h0, $past(req.c)} + {32'h0, $past(req.d)});
   endproperty
   a_umlal: assert property (p_umlal) else $error("double acc wrong");

   property p_byte_reverse_halves;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_byte_reverse_halves
         |=> res.lo == {$past(req.a[23:16]), $past(req.a[31:24]),
                        $past(req.a[7:0]), $past(req.a[15:8])};
   endproperty
   a_byte_reverse_halves: assert property (p_byte_reverse_halves) else $error("half reverse wrong");

   property p_byte_reverse_low_signed;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_byte_reverse_low_signed
         |=> res.lo[31:16] == {16{$past(req.a[7])}}
             && res.lo[15:0] == {$past(req.a[7:0]), $past(req.a[15:8])};
   endproperty
   a_byte_reverse_low_signed: assert property (p_byte_reverse_low_signed) else $error("signed reverse wrong");

   property p_sfx;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_signed_field_extract
         |=> $signed(res.lo) == ($signed(($past(req.a) >> $past(req.lsb))
                                 << (5'h1f - $past(req.width_m1)))
                                 >>> (5'h1f - $past(req.width_m1)));
   endproperty
   a_sfx: assert property (p_sfx) else $error("signed extract wrong");

   property p_ufx;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_unsigned_field_extract
         |=> res.lo == (($past(req.a) >> $past(req.lsb))
                        & ~(32'hffff_fffe << $past(req.width_m1)));
   endproperty
   a_ufx: assert property (p_ufx) else $error("unsigned extract wrong");

   property p_ldm;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_block_load_ascending
         |=> res.addr == $past(req.a)
             && res.xfer_count == 5'($countones($past(req.reglist)))
             && res.base_new == res.addr + {25'h0, res.xfer_count, 2'b00};
   endproperty
   a_ldm: assert property (p_ldm) else $error("load addr wrong");

   property p_msr;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_write_special_reg && req.set_flags
         |=> flags.n == $past(req.a[31]) && flags.z == $past(req.a[30])
             && flags.c == $past(req.a[29]) && flags.v == $past(req.a[28])
             && $stable(flags.q);
   endproperty
   a_msr: assert property (p_msr) else $error("flag write wrong");

   property p_mrs;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_read_special_reg
         |=> res.lo[31:27] == $past(flags) && $stable(flags);
   endproperty
   a_mrs: assert property (p_mrs) else $error("flag read wrong");

   property p_unmask;
      @(posedge clock) disable iff (!rstn)
      req.valid && req.op == dp_pkg::op_irq_mask_clear |=> !irq_masked && $stable(flags);
   endproperty
   a_unmask: assert property (p_unmask) else $error("mask not cleared");

   // without the flag form no op may touch any flag
   property p_noflag;
      @(posedge clock) disable iff (!rstn)
      req.valid && !req.set_flags |=> $stable(flags);
   endproperty
   a_noflag: assert property (p_noflag) else $error("flags changed");
endmodule
`default_nettype wire

// >>> half_mem.sv
`timescale 1ns/1ps
`default_nettype none
module half_mem (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire dp_pkg::req_t req,
   input  wire dp_pkg::res_t res,
   output logic [15:0]       half_rdata
);
   logic        pend_r;
   logic        pend_nxt;
   logic [15:0] last_r;
   logic [15:0] last_nxt;
   // answer only in the cycle after a halfword load issues
   always_comb begin
      pend_nxt = req.valid && (req.op == dp_pkg::op_load_half_sign_ext);
      half_rdata = pend_r ? (res.addr[15:0] ^ 16'ha5c3) : ~last_r;
      last_nxt = half_rdata;
   end
   // idle bus flips every cycle so stale data never looks right
   always_ff @(posedge clock) begin
      pend_r <= rstn & pend_nxt;
      last_r <= last_nxt;
   end
endmodule
`default_nettype wire

// >>> int_datapath_test.sv
`timescale 1ns/1ps
`default_nettype none
module int_datapath_test;
   logic           clock;
   logic           rstn;
   dp_pkg::req_t   req;
   logic [15:0]    half_rdata;
   dp_pkg::res_t   res;
   dp_pkg::flags_t flags;
   logic           irq_masked;
   dp_pkg::res_t   got;
   dp_pkg::flags_t fx;
   logic [31:0]    addr1;
   int             mismatches;
   int             checked;

   int_datapath i_int_datapath (.clock(clock), .rstn(rstn), .req(req),
      .half_rdata(half_rdata), .res(res), .flags(flags), .irq_masked(irq_masked));
   half_mem i_half_mem (.clock(clock), .rstn(rstn), .req(req), .res(res),
      .half_rdata(half_rdata));

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   function automatic dp_pkg::req_t mk(dp_pkg::op_t op, logic [31:0] a, b, c, d);
      mk = '{1'b1, op, 1'b0, 1'b0, a, b, c, d, 5'h00, 5'h00, 16'h0000};
   endfunction

   // one request, wait for the answer pulse, flags must match the model
   task automatic run(input dp_pkg::req_t r);
      int n;
      n = 0;
      @(posedge clock);
      req <= r;
      @(posedge clock);
      req <= '0;
      // the answer stands right after this edge; look before the next
      #1;
      addr1 = res.addr;
      while (res.valid !== 1'b1 && n < 4) begin
         @(posedge clock);
         #1;
         n++;
      end
      got = res;
      chk("res_valid", 64'h1, {63'h0, res.valid});
      chk("flags", {59'h0, fx}, {59'h0, flags});
   endtask

   task automatic t_branch();
      run(mk(dp_pkg::op_branch_if_zero, 32'h0, 32'h0, 32'h0, 32'h0));
      chk("bz_0", 64'h1, {63'h0, got.branch_taken});
      run(mk(dp_pkg::op_branch_if_zero, 32'h8000_0000, 32'h0, 32'h0, 32'h0));
      chk("bz_1", 64'h0, {63'h0, got.branch_taken});
      run(mk(dp_pkg::op_branch_if_nonzero, 32'h0, 32'h0, 32'h0, 32'h0));
      chk("bnz_0", 64'h0, {63'h0, got.branch_taken});
      run(mk(dp_pkg::op_branch_if_nonzero, 32'h1, 32'h0, 32'h0, 32'h0));
      chk("bnz_1", 64'h1, {63'h0, got.branch_taken});
      $display("test branch done");
   endtask

   task automatic t_mul();
      run(mk(dp_pkg::op_mul_accumulate, 32'hffff_fffe, 32'h3, 32'h10, 32'h0));
      chk("mla", 64'ha, {32'h0, got.lo});
      run(mk(dp_pkg::op_signed_long_mul, 32'hffff_fffe, 32'h3, 32'h0, 32'h0));
      chk("smul", 64'hffff_ffff_ffff_fffa, {got.hi, got.lo});
      chk("hi_valid", 64'h1, {63'h0, got.hi_valid});
      run(mk(dp_pkg::op_signed_long_mul_acc, 32'hffff_fffe, 32'h3, 32'h0, 32'h1));
      chk("smacc", 64'hffff_fffa, {got.hi, got.lo});
      run(mk(dp_pkg::op_unsigned_long_mul_double_acc, '1, '1, '1, '1));
      chk("umacc", 64'hffff_ffff_ffff_ffff, {got.hi, got.lo});
      $display("test multiply done");
   endtask

   task automatic t_bits();
      dp_pkg::req_t r;
      run(mk(dp_pkg::op_byte_reverse_word, 32'h1234_56f8, 32'h0, 32'h0, 32'h0));
      chk("rev", 64'hf856_3412, {32'h0, got.lo});
      run(mk(dp_pkg::op_byte_reverse_halves, 32'h1234_56f8, 32'h0, 32'h0, 32'h0));
      chk("byte_reverse_halves", 64'h3412_f856, {32'h0, got.lo});
      run(mk(dp_pkg::op_byte_reverse_low_signed, 32'h1234_56f8, 32'h0, 32'h0, 32'h0));
      chk("byte_reverse_low_signed_n", 64'hffff_f856, {32'h0, got.lo});
      run(mk(dp_pkg::op_byte_reverse_low_signed, 32'h1234_5678, 32'h0, 32'h0, 32'h0));
      chk("byte_reverse_low_signed_p", 64'h7856, {32'h0, got.lo});
      r = mk(dp_pkg::op_signed_field_extract, 32'hf0f0_5a5a, 32'h0, 32'h0, 32'h0);
      r.lsb = 5'h04;
      r.width_m1 = 5'h07;
      run(r);
      chk("sfx", 64'hffff_ffa5, {32'h0, got.lo});
      r.op = dp_pkg::op_unsigned_field_extract;
      run(r);
      chk("ufx", 64'ha5, {32'h0, got.lo});
      r.lsb = 5'h1c;
      r.width_m1 = 5'h03;
      run(r);
      chk("ufx_top", 64'hf, {32'h0, got.lo});
      $display("test bits done");
   endtask

   // flag write, read back, rotate through carry, interrupt mask
   task automatic t_state();
      dp_pkg::req_t r;
      r = mk(dp_pkg::op_write_special_reg, 32'h3000_0000, 32'h0, 32'h0, 32'h0);
      r.set_flags = 1'b1;
      fx = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      run(r);
      run(mk(dp_pkg::op_read_special_reg, 32'h0, 32'h0, 32'h0, 32'h0));
      chk("mrs", 64'h06, {59'h0, got.lo[31:27]});
      r = mk(dp_pkg::op_rotate_through_carry, 32'h1, 32'h0, 32'h0, 32'h0);
      r.set_flags = 1'b1;
      fx = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      run(r);
      chk("rrxs", 64'h8000_0000, {32'h0, got.lo});
      run(mk(dp_pkg::op_rotate_through_carry, 32'h2, 32'h0, 32'h0, 32'h0));
      chk("rrx", 64'h8000_0001, {32'h0, got.lo});
      run(mk(dp_pkg::op_irq_mask_set, 32'h0, 32'h0, 32'h0, 32'h0));
      chk("irq_off", 64'h1, {63'h0, irq_masked});
      run(mk(dp_pkg::op_irq_mask_clear, 32'h0, 32'h0, 32'h0, 32'h0));
      chk("irq_on", 64'h0, {63'h0, irq_masked});
      $display("test state done");
   endtask

   task automatic t_mem();
      dp_pkg::req_t r;
      r = mk(dp_pkg::op_block_store_descending, 32'h1000, 32'h0, 32'h0, 32'h0);
      r.reglist = 16'h8013;
      r.wback = 1'b1;
      run(r);
      chk("block_store_descending", 64'h0ff0_0000_0ff0, {got.addr, got.base_new});
      chk("block_store_descending_n", 64'h09, {got.xfer_count, got.base_we});
      r = mk(dp_pkg::op_block_load_ascending, 32'h2000, 32'h0, 32'h0, 32'h0);
      r.reglist = 16'hffff;
      run(r);
      chk("ldm", 64'h2000_0000_0000, {got.addr, 31'h0, got.base_we});
      chk("ldm_base", 64'h10_0000_2040, {got.xfer_count, got.base_new});
      run(mk(dp_pkg::op_load_half_sign_ext, 32'h3000, 32'h6, 32'h0, 32'h0));
      chk("load_half_sign_ext", 64'h3006_ffff_95c5, {addr1, got.lo});
      $display("test memory done");
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // free-running clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // hang guard, well beyond the fewer than 60 cycles needed
   initial begin
      repeat (3000) @(posedge clock);
      mismatches++;
      complete_run();
   end
   initial begin
      rstn = 1'b0;
      req = '0;
      fx = '0;
      mismatches = 0;
      checked = 0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      #1;
      chk("reset", 64'h0, {57'h0, res.valid, flags, irq_masked});
      t_branch();
      t_mul();
      t_bits();
      t_state();
      t_mem();
      complete_run();
   end
endmodule
`default_nettype wire
